// ### hw/sar_pkg.sv
// Shared constants and types of the serial converter readout.
package sar_pkg;
  localparam int SAR_CODE_W = 10;
  localparam int SAR_FRAME_W = 16;
  localparam int SAR_CNT_W = 5;
  localparam logic [3:0] SAR_LEAD_ZEROS = 4'h0;
  localparam logic [1:0] SAR_TRAIL_ZEROS = 2'h0;
  localparam logic [SAR_CNT_W-1:0] SAR_CNT_RST = 5'h00;
  localparam logic [SAR_CNT_W-1:0] SAR_PD_FIRST_FALL = 5'h02;
  localparam logic [SAR_CNT_W-1:0] SAR_PD_END_FALL = 5'h0a;
  localparam logic [SAR_CNT_W-1:0] SAR_WAKE_FALL = 5'h0a;
  localparam logic [SAR_CNT_W-1:0] SAR_ACQ_FALL = 5'h0d;
  localparam logic [SAR_CNT_W-1:0] SAR_LAST_FALL = 5'h10;

  typedef enum logic [1:0] {
    SAR_IDLE = 2'h0,
    SAR_SHIFT = 2'h1,
    SAR_TAIL = 2'h3
  } sar_state_e;

  typedef struct packed {
    logic powered_down;
    logic converting;
  } sar_stat_s;
endpackage

// ### hw/sar_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module sar_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### hw/sar_readout.sv
// Serial readout and power control of the sampling converter.
`timescale 1ns/10ps
`default_nettype none
module sar_readout (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sel_b,
  input wire logic sclk,
  input wire logic [sar_pkg::SAR_CODE_W-1:0] analog_input,
  output logic serial_out,
  output logic serial_out_oe,
  output sar_pkg::sar_stat_s stat
);
  import sar_pkg::*;

  logic sel_s, sel_q, sclk_s, sclk_q;
  logic [SAR_CODE_W-1:0] ana_s;
  logic [SAR_CODE_W-1:0] code_r;
  logic [SAR_FRAME_W-1:0] frame_r;
  logic [SAR_CNT_W-1:0] cnt_r;
  sar_state_e state_r;
  logic sel_fall, sel_rise, sclk_fall, sclk_rise, in_cycle, pd_win;
  // Each status flag has its own flop so that exactly one process owns it.
  logic pd_r, conv_r;

  sar_sync #(.W(1), .RST_VAL(1'h1)) u_sel_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din(sel_b),
    .dout(sel_s)
  );

  sar_sync #(.W(1), .RST_VAL(1'h0)) u_sclk_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din(sclk),
    .dout(sclk_s)
  );

  // The input is treated as quasi-static around the sampling instant.
  sar_sync #(.W(SAR_CODE_W), .RST_VAL('0)) u_ana_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din(analog_input),
    .dout(ana_s)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_q <= 1'h1;
      sclk_q <= 1'h0;
    end else begin
      sel_q <= sel_s;
      sclk_q <= sclk_s;
    end
  end

  // Pin edges take effect three clock edges after they occur, so the host
  // must keep every shift-clock phase at least four clocks long.
  assign sel_fall = sel_q & ~sel_s;
  assign sel_rise = ~sel_q & sel_s;
  assign sclk_fall = sclk_q & ~sclk_s;
  assign sclk_rise = ~sclk_q & sclk_s;
  assign in_cycle = (state_r != SAR_IDLE);
  assign pd_win = (cnt_r >= SAR_PD_FIRST_FALL) && (cnt_r < SAR_PD_END_FALL);
  assign stat = '{powered_down: pd_r, converting: conv_r};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      code_r <= '0;
    end else if (sel_fall) begin
      code_r <= ana_s;
    end
  end

  // Frame sequencing and the output pin.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= SAR_IDLE;
      cnt_r <= SAR_CNT_RST;
      frame_r <= '0;
      serial_out <= 1'h0;
      serial_out_oe <= 1'h0;
    end else if (sel_rise) begin
      state_r <= SAR_IDLE;
      serial_out <= 1'h0;
      serial_out_oe <= 1'h0;
    end else if (sel_fall) begin
      state_r <= SAR_SHIFT;
      cnt_r <= SAR_CNT_RST;
      serial_out <= 1'h0;
      serial_out_oe <= 1'h1;
      frame_r <= {SAR_LEAD_ZEROS, pd_r ? {SAR_CODE_W{1'b0}} : ana_s,
                  SAR_TRAIL_ZEROS};
    end else if (sclk_fall && in_cycle) begin
      cnt_r <= cnt_r + 5'h01;
      case (state_r)
        SAR_SHIFT: begin
          if (cnt_r == SAR_LAST_FALL - 5'h01) begin
            state_r <= SAR_TAIL;
            serial_out <= 1'h0;
            serial_out_oe <= 1'h0;
          end else begin
            serial_out <= frame_r[SAR_FRAME_W-2];
            frame_r <= {frame_r[SAR_FRAME_W-2:0], 1'h0};
          end
        end
        SAR_TAIL: begin
          // Extra edges after the frame keep the pin released; the count
          // saturates so a very long dummy cycle cannot wrap it.
          cnt_r <= cnt_r;
        end
        default: begin
          state_r <= SAR_IDLE;
        end
      endcase
    end
  end

  // Power-down entry and wake-up.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pd_r <= 1'h0;
    end else if (sel_rise && in_cycle && pd_win) begin
      pd_r <= 1'h1;
    end else if (sclk_fall && in_cycle && !sel_rise &&
                 cnt_r == SAR_WAKE_FALL - 5'h01) begin
      pd_r <= 1'h0;
    end
  end

  // Conversion busy until the acquisition point or an abort.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      conv_r <= 1'h0;
    end else if (sel_fall) begin
      conv_r <= 1'h1;
    end else if (sel_rise) begin
      conv_r <= 1'h0;
    end else if (sclk_rise && cnt_r >= SAR_ACQ_FALL) begin
      conv_r <= 1'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_CAPTURE: assert property (sel_fall |=> code_r == $past(ana_s))
    else $error("sample not captured on select fall");
  AST_FIRST_ZERO: assert property (
    sel_fall |=> serial_out_oe && !serial_out)
    else $error("first bit not a driven zero");
  AST_RELEASE_16: assert property (
    state_r == SAR_SHIFT && sclk_fall && !sel_rise &&
    cnt_r == SAR_LAST_FALL - 5'h01 |=> !serial_out_oe ##1 !serial_out_oe)
    else $error("output not released after last edge");
  AST_ABORT: assert property (sel_rise |=> !serial_out_oe)
    else $error("output still driven after deselect");
  AST_PD_ENTER: assert property (
    sel_rise && in_cycle && pd_win |=> stat.powered_down)
    else $error("no power-down on window deselect");
  AST_PD_LATE: assert property (
    sel_rise && cnt_r >= SAR_PD_END_FALL && !stat.powered_down
    |=> !stat.powered_down)
    else $error("power-down after window end");
  AST_LEAD: assert property (
    state_r == SAR_SHIFT && sclk_fall && !sel_rise && cnt_r < 5'h03
    |=> serial_out_oe && !serial_out)
    else $error("leading bit not zero");
  AST_MSB: assert property (
    state_r == SAR_SHIFT && sclk_fall && !sel_rise && cnt_r == 5'h03 &&
    !pd_r |=> serial_out == code_r[SAR_CODE_W-1])
    else $error("msb not on fourth falling edge");
  AST_PD_ZERO: assert property (
    sel_fall && stat.powered_down |=> frame_r == '0)
    else $error("powered-down frame not zero");
  AST_ACQ: assert property (
    stat.converting && sclk_rise && !sel_rise && !sel_fall &&
    cnt_r >= SAR_ACQ_FALL |=> !stat.converting)
    else $error("conversion not ended at acquisition point");
  AST_CONV_START: assert property (
    sel_fall |=> stat.converting)
    else $error("conversion not started on select fall");
  AST_CONV_ABORT: assert property (
    sel_rise |=> !stat.converting)
    else $error("conversion not stopped on deselect");
  AST_WAKE: assert property (
    sclk_fall && in_cycle && !sel_rise &&
    cnt_r == SAR_WAKE_FALL - 5'h01 |=> !stat.powered_down)
    else $error("no wake-up at tenth falling edge");
  AST_QUIET: assert property (
    !in_cycle && !sel_fall |=> !serial_out_oe)
    else $error("output driven outside a cycle");

  COV_FRAME: cover property (state_r == SAR_SHIFT ##1 state_r == SAR_TAIL);
  COV_PD: cover property (!stat.powered_down ##1 stat.powered_down);
  COV_WAKE: cover property (stat.powered_down ##1 !stat.powered_down);
  COV_ABORT: cover property (sel_rise && state_r == SAR_SHIFT);
  COV_LATE: cover property (sel_rise && in_cycle && cnt_r >= SAR_PD_END_FALL);
endmodule
`default_nettype wire

// ### tb/sar_host_model.sv
// Host-side serial master model that drives select and the shift clock.
`timescale 1ns/10ps
`default_nettype none
module sar_host_model (
  input wire logic clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic sel_b,
  output logic sclk,
  output logic [15:0] word
);
  logic last;
  initial begin
    sel_b = 1'b1;
    sclk = 1'b0;
    word = 16'h0;
    last = 1'b0;
  end
  task automatic run(input int n);
    sel_b <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      // Sample before fall.
      // A released line reads as the inverse, so stale bits never match.
      last = serial_out_oe ? serial_out : ~last;
      word = {word[14:0], last};
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    sel_b <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### tb/sar_readout_tb.sv
// Self-checking bench of the serial converter readout.
`timescale 1ns/10ps
`default_nettype none
module sar_readout_tb;
  import sar_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [SAR_CODE_W-1:0] ain = 10'h000;
  logic sel_b;
  logic sclk;
  logic so;
  logic oe;
  logic [15:0] word;
  sar_stat_s stat;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  sar_readout sar_readout_i (.clk(clk), .rst_b(rst_b), .sel_b(sel_b),
    .sclk(sclk), .analog_input(ain), .serial_out(so),
    .serial_out_oe(oe), .stat(stat));
  sar_host_model sar_host_model_i (.clk(clk), .serial_out(so),
    .serial_out_oe(oe), .sel_b(sel_b), .sclk(sclk), .word(word));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The input moves after select falls, so a late sample shows up.
  task automatic frame_ok(input logic [9:0] c);
    ain <= c;
    repeat (4) @(posedge clk);
    fork
      sar_host_model_i.run(16);
      begin
        repeat (12) @(posedge clk);
        ain <= ~c;
        chk({15'h0, stat.converting}, 16'h1);
        repeat (100) @(posedge clk);
        chk({15'h0, stat.converting}, 16'h1);
        repeat (6) @(posedge clk);
        chk({15'h0, stat.converting}, 16'h0);
      end
    join
    chk(word, {4'h0, c, 2'h0});
    chk(word, {SAR_LEAD_ZEROS, c, SAR_TRAIL_ZEROS});
    chk({15'h0, oe}, 16'h0);
    chk({15'h0, stat.powered_down}, 16'h0);
  endtask
  // Deselect at the window edges, then a full wake frame each time.
  task automatic pd_window();
    int nf[4] = '{1, 2, 9, 10};
    logic pd;
    for (int i = 0; i < 4; i++) begin
      ain <= 10'h155;
      sar_host_model_i.run(nf[i]);
      pd = (nf[i] >= 2 && nf[i] < 10);
      chk({15'h0, oe}, 16'h0);
      chk({15'h0, stat.converting}, 16'h0);
      chk({15'h0, stat.powered_down}, {15'h0, pd});
      sar_host_model_i.run(16);
      chk(word, pd ? 16'h0 : {4'h0, 10'h155, 2'h0});
      chk({15'h0, stat.powered_down}, 16'h0);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    frame_ok(10'h2a5);
    frame_ok(10'h3ff);
    pd_window();
    frame_ok(10'h001);
    end_of_test();
  end
endmodule
`default_nettype wire
